/* verilog/sfr_gate_pkg.sv */
// constants and types for the special function register access gate
// assumes a cpu core that presents one register access per cycle
package sfr_gate_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int NUM_HW = 16;
   // cpu modes, one-hot
   typedef enum logic [2:0] {
      MODE_SYSTEM = 3'b001,
      MODE_FIRMWARE = 3'b010,
      MODE_USER = 3'b100
   } cpu_mode_t;
   // fixed address map of register classes
   localparam logic [ADDR_W-1:0] CPU_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] CPU_TOP = 8'h3F;
   localparam logic [ADDR_W-1:0] HW_BASE = 8'h40;
   localparam logic [ADDR_W-1:0] HW_TOP = 8'h7F;
   localparam logic [ADDR_W-1:0] MMU_BASE = 8'h80;
   localparam logic [ADDR_W-1:0] MMU_TOP = 8'h8F;
   localparam logic [ADDR_W-1:0] SEG_PTR_ADDR = 8'h80;
   localparam logic [ADDR_W-1:0] USER_GRANT_ADDR = 8'h81;
   localparam logic [ADDR_W-1:0] FW_GRANT_ADDR = 8'h82;
   // hw registers grouped four addresses to a grant bit
   localparam int HW_GROUP_SHIFT = 2;
   localparam logic [NUM_HW-1:0] GRANT_RST = 16'h0000;
   localparam logic [DATA_W-1:0] REG_RST = 8'h00;
endpackage

/* verilog/sfr_store.sv */
// storage for the gated special function registers
// assumes writes arrive only when the gate has allowed them
`timescale 1ns/1ps
module sfr_store
   import sfr_gate_pkg::*;
#(
   parameter int AW = ADDR_W,
   parameter int DW = DATA_W
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic we,
   input wire logic re,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] wdata,
   output logic [DW-1:0] rdata_q
);
   logic [DW-1:0] mem_q [0:(1<<AW)-1];
   // every word starts from the default value after reset
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < (1<<AW); i++) begin
            mem_q[i] <= REG_RST; // RULE_05
         end
      end else if (we) begin
         mem_q[addr] <= wdata;
      end
   end
   // registered read, zero when no read was allowed
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= REG_RST;
      end else begin
         rdata_q <= re ? mem_q[addr] : REG_RST; // RULE_08
      end
   end
endmodule

/* verilog/sfr_mode_access_control.sv */
// mode based gate in front of the special function register space
// assumes cpu_mode is synchronous to clk_sys and one access per cycle
//
// Operation
// (RULE_01) memory-management registers are reachable only in system mode.
// (RULE_02) hardware component registers are reachable in system mode.
// (RULE_03) user mode reaches only cpu registers by default.
// (RULE_04) a user grant bit opens its hardware register group to user mode.
// (RULE_05) after reset every register and every grant has a defined default.
// (RULE_06) register classes are fixed; only user and firmware grants can change.
// (RULE_07) the segment table pointer can be written only in system mode.
// (RULE_08) a blocked access changes nothing, reads zero and flags a violation.
//
// address map, fixed in hardware:
//    0x00-0x3f cpu core registers, open in every legal mode
//    0x40-0x7f hardware component registers, four addresses to a grant group
//    0x80-0x8f memory management registers, system mode only
//    0x80 segment table pointer, 0x81 user grant, 0x82 firmware grant
//    anything above 0x8f is unmapped and always refused
// grant writes carry eight bits, so only groups 0 to 7 can ever open;
// groups 8 to 15 stay closed, which errs on the safe side
// a mode word with no bit or more than one bit set matches no mode,
// so a glitched mode can only lose access, never gain it
`timescale 1ns/1ps
module sfr_mode_access_control
   import sfr_gate_pkg::*;
#(
   parameter int NHW = NUM_HW
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [2:0] cpu_mode,
   input wire logic req_valid,
   input wire logic req_write,
   input wire logic [ADDR_W-1:0] req_addr,
   input wire logic [DATA_W-1:0] req_wdata,
   output logic [DATA_W-1:0] rsp_rdata_q,
   output logic rsp_valid_q,
   output logic violation_q,
   output logic [NHW-1:0] user_grant_q,
   output logic [NHW-1:0] fw_grant_q
);
   // ****************************************
   // class decode
   // ****************************************
   // mode decode; exact compares so that illegal codes match no mode
   wire is_sys = (cpu_mode == MODE_SYSTEM);
   wire is_fw = (cpu_mode == MODE_FIRMWARE);
   wire is_user = (cpu_mode == MODE_USER);
   // address class against the fixed map
   wire in_cpu = (req_addr <= CPU_TOP);
   wire in_hw = (req_addr >= HW_BASE) && (req_addr <= HW_TOP);
   wire in_mmu = (req_addr >= MMU_BASE) && (req_addr <= MMU_TOP);
   // grant group of a hardware register, four addresses to one bit
   wire [ADDR_W-1:0] hw_off = req_addr - HW_BASE;
   wire [3:0] hw_group = hw_off[HW_GROUP_SHIFT+3:HW_GROUP_SHIFT];
   // grant bits are the only changeable attribute; class map above is fixed
   wire user_ok = user_grant_q[hw_group]; // RULE_04
   wire fw_ok = fw_grant_q[hw_group];
   // per class verdict for the current mode
   wire hw_allow = is_sys || (is_user && user_ok) || (is_fw && fw_ok); // RULE_02 RULE_03
   wire mmu_allow = is_sys; // RULE_01 RULE_07
   wire cpu_allow = is_sys || is_fw || is_user; // RULE_03
   wire allow = in_cpu ? cpu_allow : in_hw ? hw_allow : in_mmu ? mmu_allow : 1'b0;
   // one verdict per request; unmapped addresses fall through to refused
   wire go = req_valid && allow;
   wire deny = req_valid && !allow; // RULE_08
   wire wr_go = go && req_write;
   // only allowed system mode writes ever reach the grant words
   wire user_grant_wr = wr_go && (req_addr == USER_GRANT_ADDR); // RULE_06
   wire fw_grant_wr = wr_go && (req_addr == FW_GRANT_ADDR); // RULE_06
   // ****************************************
   // grant registers
   // ****************************************
   // low byte of each grant only; upper groups stay closed by default
   // a narrow bus can only leave groups shut, never open them by accident
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         user_grant_q <= GRANT_RST; // RULE_05
         fw_grant_q <= GRANT_RST;
      end else begin
         if (user_grant_wr) user_grant_q[7:0] <= req_wdata;
         if (fw_grant_wr) fw_grant_q[7:0] <= req_wdata;
      end
   end
   // response flags, one cycle after the request
   // refused requests are answered too, so the cpu never waits on a lost access
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rsp_valid_q <= 1'b0;
         violation_q <= 1'b0;
      end else begin
         rsp_valid_q <= req_valid;
         violation_q <= deny; // RULE_08
      end
   end
   // ****************************************
   // register storage
   // ****************************************
   // storage sees only allowed traffic, so a refused write can never land
   sfr_store #(.AW(ADDR_W), .DW(DATA_W)) u_store (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .we(wr_go),
      .re(go && !req_write),
      .addr(req_addr),
      .wdata(req_wdata),
      .rdata_q(rsp_rdata_q)
   );
   // ****************************************
   // checks: mode and address class
   // ****************************************

   // memory management space refuses every mode but system
   a_mmu_sys_only: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_01
      (req_valid && in_mmu && !is_sys) |=> violation_q)
      else $error("mmu access outside system mode not flagged");

   // system mode keeps its way into the memory management space
   a_mmu_sys_ok: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_01
      (req_valid && in_mmu && is_sys) |=> !violation_q)
      else $error("system mode mmu access blocked");

   // system mode needs no grant for hardware registers
   a_hw_sys_ok: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_02
      (req_valid && in_hw && is_sys) |=> !violation_q)
      else $error("system mode hw access blocked");

   // cpu core registers stay open in each legal mode
   a_cpu_open: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_03
      (req_valid && in_cpu && (is_sys || is_fw || is_user)) |=> !violation_q)
      else $error("cpu register access blocked in a legal mode");

   // an illegal mode code reaches nothing at all
   a_bad_mode: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_03
      (req_valid && !(is_sys || is_fw || is_user)) |=> violation_q)
      else $error("access in an illegal mode allowed");

   // user mode without its grant is kept off hardware registers
   a_user_default: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_03
      (req_valid && in_hw && is_user && !user_ok) |=> violation_q)
      else $error("user hw access without grant allowed");

   // a set user grant opens its group
   a_user_grant: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_04
      (req_valid && in_hw && is_user && user_ok) |=> !violation_q)
      else $error("granted user access blocked");

   // firmware mode needs a grant of its own for hardware registers
   a_fw_default: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06
      (req_valid && in_hw && is_fw && !fw_ok) |=> violation_q)
      else $error("firmware hw access without grant allowed");

   // a set firmware grant opens its group
   a_fw_grant: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06
      (req_valid && in_hw && is_fw && fw_ok) |=> !violation_q)
      else $error("granted firmware access blocked");

   // a segment pointer write from a lower mode must be flagged
   a_segptr_sys: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_07
      (req_valid && req_write && req_addr == SEG_PTR_ADDR && !is_sys) |=> violation_q)
      else $error("segment pointer write outside system mode");

   // nothing beyond the mapped space is ever reachable
   a_unmapped_addr: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_08
      (req_valid && !in_cpu && !in_hw && !in_mmu) |=> violation_q)
      else $error("unmapped access allowed");

   // ****************************************
   // checks: grants and reset
   // ****************************************

   // both grant words leave reset closed
   a_grant_reset: assert property (@(posedge clk_sys) // RULE_05
      $rose(arst_n) |-> (user_grant_q == GRANT_RST) && (fw_grant_q == GRANT_RST))
      else $error("grants not at default after reset");

   // grants move only on an allowed write to their own address
   a_grant_stable: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06
      !(user_grant_wr) |=> $stable(user_grant_q))
      else $error("user grant changed without allowed write");

   // the same holds for the firmware grant
   a_fw_stable: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06
      !(fw_grant_wr) |=> $stable(fw_grant_q))
      else $error("firmware grant changed without allowed write");

   // an allowed user grant write takes the byte from the bus
   a_grant_load: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_04
      user_grant_wr |=> (user_grant_q[7:0] == $past(req_wdata)))
      else $error("user grant did not take the written byte");

   // an allowed firmware grant write takes the byte from the bus
   a_fw_load: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06
      fw_grant_wr |=> (fw_grant_q[7:0] == $past(req_wdata)))
      else $error("firmware grant did not take the written byte");

   // a user grant read back through storage matches the live grant
   a_user_grant_rd: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06
      (go && !req_write && req_addr == USER_GRANT_ADDR) |=> rsp_rdata_q == user_grant_q[7:0])
      else $error("user grant read back differs from live grant");

   // a firmware grant read back through storage matches the live grant
   a_fw_grant_rd: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_06
      (go && !req_write && req_addr == FW_GRANT_ADDR) |=> rsp_rdata_q == fw_grant_q[7:0])
      else $error("firmware grant read back differs from live grant");

   // ****************************************
   // checks: response
   // ****************************************

   // every request is answered one cycle later
   a_rsp_once: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_08
      req_valid |=> rsp_valid_q)
      else $error("request not answered");

   // no answer and no violation without a request
   a_rsp_idle: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_08
      !req_valid |=> (!rsp_valid_q && !violation_q))
      else $error("response or violation without a request");

   // a refused read returns the reset value, never the stored word
   a_deny_zero: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_08
      (deny && !req_write) |=> (rsp_rdata_q == REG_RST) && rsp_valid_q)
      else $error("blocked read returned data");

   // a write returns no data, allowed or not
   a_write_no_data: assert property (@(posedge clk_sys) disable iff (!arst_n) // RULE_08
      (req_valid && req_write) |=> (rsp_rdata_q == REG_RST))
      else $error("write returned read data");
endmodule

/* verification/sfr_cpu_model.sv */
// cpu core model issuing one register access at a time
// assumes the gate answers exactly one cycle after taking a request
`timescale 1ns/1ps
module sfr_cpu_model
   import sfr_gate_pkg::*;
(
   input wire logic clk_sys,
   output logic [2:0] cpu_mode,
   output logic req_valid,
   output logic req_write,
   output logic [ADDR_W-1:0] req_addr,
   output logic [DATA_W-1:0] req_wdata,
   input wire logic [DATA_W-1:0] rsp_rdata_q,
   input wire logic rsp_valid_q,
   input wire logic violation_q
);
   // idle bus at time zero
   initial begin
      {cpu_mode, req_valid, req_write, req_addr, req_wdata} = {MODE_SYSTEM, 18'h0_0000};
   end
   // released lines show the inverse so stale values cannot pass for live ones
   task automatic acc(input logic [2:0] m, input logic w, input logic [7:0] a, d,
      output logic [7:0] rd, output logic [1:0] st);
      @(posedge clk_sys);
      {cpu_mode, req_valid, req_write, req_addr, req_wdata} <= {m, 1'b1, w, a, d};
      @(posedge clk_sys);
      {req_valid, req_addr, req_wdata} <= {1'b0, ~a, ~d};
      #1;
      rd = rsp_rdata_q;
      st = {rsp_valid_q, violation_q};
   endtask
endmodule

/* verification/tb_sfr_mode_access_control.sv */
// self-checking bench for the register access gate
// assumes the cpu model keeps the one-cycle response contract
`timescale 1ns/1ps
module tb_sfr_mode_access_control;
   import sfr_gate_pkg::*;
   logic clk_sys, arst_n, req_valid, req_write, rsp_valid_q, violation_q;
   logic [2:0] cpu_mode;
   logic [7:0] req_addr, req_wdata, rsp_rdata_q;
   logic [15:0] user_grant_q, fw_grant_q;
   int fails = 0;
   int n_checks = 0;
   localparam logic [2:0] SY = MODE_SYSTEM, FW = MODE_FIRMWARE, US = MODE_USER;
   sfr_mode_access_control i_dut (.clk_sys, .arst_n, .cpu_mode, .req_valid, .req_write,
      .req_addr, .req_wdata, .rsp_rdata_q, .rsp_valid_q, .violation_q, .user_grant_q,
      .fw_grant_q);
   sfr_cpu_model i_cpu (.clk_sys, .cpu_mode, .req_valid, .req_write, .req_addr,
      .req_wdata, .rsp_rdata_q, .rsp_valid_q, .violation_q);
   // 125 MHz system clock
   initial begin
      clk_sys = 0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [15:0] got, exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // one access; every answer must be valid, blocked ones must flag
   task automatic op(input logic [2:0] m, input logic w, input logic [7:0] a, d, er,
      input logic ev);
      logic [7:0] rd;
      logic [1:0] st;
      i_cpu.acc(m, w, a, d, rd, st);
      chk({8'h00, rd}, {8'h00, er});
      chk({14'h0000, st}, {14'h0000, 1'b1, ev});
   endtask
   task automatic sc_reset;
      chk(user_grant_q | fw_grant_q, GRANT_RST);
      chk({14'h0000, rsp_valid_q, violation_q}, 16'h0000);
      op(SY, 0, SEG_PTR_ADDR, 8'h00, REG_RST, 0);
   endtask
   task automatic sc_mmu;
      op(US, 1, SEG_PTR_ADDR, 8'h5a, 8'h00, 1);
      op(FW, 1, SEG_PTR_ADDR, 8'h5a, 8'h00, 1);
      op(SY, 0, SEG_PTR_ADDR, 8'h00, 8'h00, 0);
      op(SY, 1, SEG_PTR_ADDR, 8'ha5, 8'h00, 0);
      op(US, 0, SEG_PTR_ADDR, 8'h00, 8'h00, 1);
      op(SY, 0, SEG_PTR_ADDR, 8'h00, 8'ha5, 0);
      op(SY, 0, 8'h90, 8'h00, 8'h00, 1);
   endtask
   task automatic sc_hw;
      op(SY, 1, 8'h44, 8'h3c, 8'h00, 0);
      op(US, 1, 8'h44, 8'hff, 8'h00, 1);
      op(SY, 0, 8'h44, 8'h00, 8'h3c, 0);
      op(US, 0, 8'h44, 8'h00, 8'h00, 1);
      op(FW, 0, 8'h44, 8'h00, 8'h00, 1);
      op(US, 1, 8'h3f, 8'h77, 8'h00, 0);
      op(US, 0, 8'h3f, 8'h00, 8'h77, 0);
      op(3'b011, 0, 8'h3f, 8'h00, 8'h00, 1);
   endtask
   task automatic sc_grant;
      op(US, 1, USER_GRANT_ADDR, 8'h02, 8'h00, 1);
      chk(user_grant_q, GRANT_RST);
      op(SY, 1, USER_GRANT_ADDR, 8'h02, 8'h00, 0);
      chk(user_grant_q, 16'h0002);
      op(US, 0, 8'h44, 8'h00, 8'h3c, 0);
      op(US, 0, 8'h48, 8'h00, 8'h00, 1);
      op(SY, 1, FW_GRANT_ADDR, 8'h04, 8'h00, 0);
      chk(fw_grant_q, 16'h0004);
      op(FW, 0, 8'h48, 8'h00, REG_RST, 0);
      op(SY, 0, USER_GRANT_ADDR, 8'h00, 8'h02, 0);
      op(SY, 0, FW_GRANT_ADDR, 8'h00, 8'h04, 0);
      op(FW, 1, FW_GRANT_ADDR, 8'hff, 8'h00, 1);
      chk(fw_grant_q, 16'h0004);
      op(FW, 1, 8'h49, 8'h5a, 8'h00, 0);
      op(SY, 0, 8'h49, 8'h00, 8'h5a, 0);
   endtask
   // reset in mid-run: grants and stored words fall back to their defaults
   task automatic sc_rereset;
      @(posedge clk_sys);
      arst_n <= 0;
      repeat (2) @(posedge clk_sys);
      chk(user_grant_q | fw_grant_q, GRANT_RST);
      arst_n <= 1;
      op(SY, 0, 8'h44, 8'h00, REG_RST, 0);
      op(US, 0, 8'h44, 8'h00, 8'h00, 1);
      chk(user_grant_q, GRANT_RST);
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // reset held five cycles, then the scenarios in order
   initial begin
      arst_n = 0;
      repeat (5) @(posedge clk_sys);
      arst_n <= 1;
      sc_reset();
      sc_mmu();
      sc_hw();
      sc_grant();
      sc_rereset();
      finish_test();
   end
endmodule
